// ### core/pfou_core.sv
// port and flag command unit: range ops, pulses, waits and binary reads
////////////////////////////////////////////////////////////////////////////////
// Contract
// - range op touches first through last index
// - set drives on, clear off, toggle inverts
// - on pulse: on now, off at expiry
// - intervals 0.01 to 99.00 s, hundredths
// - on pulse ends off even if already on
// - program end keeps on, drops turn-off
// - timer cancel never touches pulse timers
// - sixteen concurrent pulse timers per program
// - off pulse: off now, on at expiry
// - off pulse ends on even if already off
// - program end keeps off, drops turn-on
// - level wait stalls until target matches level
// - timed wait aborts and flags timeout result
// - binary read packs range, first at lsb
// - binary read spans at most 32 points
// - full 32-bit read with top bit is negative
// - format code swaps bytes and halves
// - timer cancel ends a level wait
////////////////////////////////////////////////////////////////////////////////
module pfou_core #(
    parameter int NUM_PTS     = pfou_pkg::NUM_PTS,
    parameter int IN_PTS      = pfou_pkg::IN_PTS,
    parameter int NUM_PROGS   = pfou_pkg::NUM_PROGS,
    parameter int TICK_CYCLES = pfou_pkg::TICK_CYCLES,
    parameter int IDX_W       = $clog2(NUM_PTS),
    parameter int PROG_W      = $clog2(NUM_PROGS)
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic                  cmdValid,
    output logic                       cmdReady,
    input  wire pfou_pkg::pfou_op_t    cmdOp,
    input  wire logic [PROG_W-1:0]     cmdProg,
    input  wire logic [IDX_W-1:0]      cmdFirst,
    input  wire logic [IDX_W-1:0]      cmdLast,
    input  wire logic [pfou_pkg::TIME_W-1:0] cmdTime,
    input  wire logic                  cmdTimed,
    input  wire logic                  progEnd,
    input  wire logic [PROG_W-1:0]     progEndId,
    input  wire logic [IN_PTS-1:0]     inLevels,
    output logic [NUM_PTS-1:IN_PTS]    outLevels,
    output logic                       accValid,
    output logic signed [31:0]         acc,
    output logic                       waitDone,
    output logic [PROG_W-1:0]          waitDoneProg,
    output logic                       waitTimedOut
);
    localparam int TIME_W = pfou_pkg::TIME_W;
    localparam int TICK_W = $clog2(TICK_CYCLES);
    localparam int RB     = pfou_pkg::READ_BITS;

    logic [NUM_PTS-1:0] allLevels;
    logic               accept;
    logic               isRange;
    logic               isPulse;
    logic               isWait;
    logic               isCancel;
    logic [PROG_W-1:0]  cancelProg;
    logic [TICK_W-1:0]  tickCnt;
    logic               tick;
    logic [RB-1:0]      readRaw;
    logic [1:0]         fmt [NUM_PROGS];

    logic [NUM_PROGS-1:0] wActive;
    logic [NUM_PROGS-1:0] wLvl;
    logic [NUM_PROGS-1:0] wTimed;
    logic [NUM_PROGS-1:0] wCancel;
    logic [IDX_W-1:0]     wIdx [NUM_PROGS];
    logic [TIME_W-1:0]    wCnt [NUM_PROGS];
    logic                 doneHit;
    logic [PROG_W-1:0]    doneP;
    logic                 doneTo;

    pfou_timer_if #(.IDX_W(IDX_W), .PROG_W(PROG_W), .TIME_W(TIME_W)) t ();

    ////////////////////////////////////////////////////////////////////////////
    // reordering of read data by format code
    function automatic logic [31:0] fmtSwap(input logic [31:0] d, input logic [1:0] f);
        logic [31:0] r;
        r = d;
        if (f[pfou_pkg::FMT_BYTE_BIT]) begin
            r = {r[23:16], r[31:24], r[7:0], r[15:8]};
        end
        if (f[pfou_pkg::FMT_HALF_BIT]) begin
            r = {r[15:0], r[31:16]};
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // command decode and acceptance
    assign allLevels  = {outLevels, inLevels};
    assign isRange    = cmdOp == pfou_pkg::OP_RANGE_SET || cmdOp == pfou_pkg::OP_RANGE_CLR
                        || cmdOp == pfou_pkg::OP_RANGE_TGL;
    assign isPulse    = cmdOp == pfou_pkg::OP_ON_PULSE || cmdOp == pfou_pkg::OP_OFF_PULSE;
    assign isWait     = cmdOp == pfou_pkg::OP_WAIT_HIGH || cmdOp == pfou_pkg::OP_WAIT_LOW;
    assign isCancel   = cmdOp == pfou_pkg::OP_TMR_CANCEL;
    assign cancelProg = cmdFirst[PROG_W-1:0];   // operand one names the program

    // a pulse stalls only while its program's timer group is full
    assign cmdReady = !(isPulse && !t.canLoad);
    assign accept   = cmdValid && cmdReady;

    ////////////////////////////////////////////////////////////////////////////
    // 10 ms tick divider shared by pulse and wait timers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt <= '0;
            tick    <= 1'b0;
        end else begin
            if (tickCnt == TICK_W'(TICK_CYCLES - 1)) begin
                tickCnt <= '0;
                tick    <= 1'b1;
            end else begin
                tickCnt <= tickCnt + TICK_W'(1);
                tick    <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pulse timer pool; program end kills its program's pulse timers, cancel never does
    assign t.load       = accept && isPulse;
    assign t.prog       = cmdProg;
    assign t.idx        = cmdFirst;
    assign t.restoreLvl = cmdOp == pfou_pkg::OP_OFF_PULSE;
    assign t.ticks      = cmdTime;
    assign t.kill       = progEnd;
    assign t.killProg   = progEndId;
    assign t.tick       = tick;

    pfou_pulse_timers #(
        .NUM_PROGS    (NUM_PROGS),
        .TMR_PER_PROG (pfou_pkg::TMR_PER_PROG),
        .IDX_W        (IDX_W),
        .PROG_W       (PROG_W),
        .TIME_W       (TIME_W)
    ) u_timers (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .t       (t.tmr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // output and flag levels; a command beats an expiry on the same point
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            outLevels <= {(NUM_PTS - IN_PTS){pfou_pkg::LVL_RESET}};
        end else begin
            for (int i = IN_PTS; i < NUM_PTS; i++) begin
                if (t.fire && int'(t.fireIdx) == i) begin
                    outLevels[i] <= t.fireLvl;
                end
                if (accept && isRange && i >= int'(cmdFirst) && i <= int'(cmdLast)) begin
                    if (cmdOp == pfou_pkg::OP_RANGE_SET) begin
                        outLevels[i] <= 1'b1;
                    end else if (cmdOp == pfou_pkg::OP_RANGE_CLR) begin
                        outLevels[i] <= 1'b0;
                    end else begin
                        outLevels[i] <= !outLevels[i];
                    end
                end
                if (t.load && int'(cmdFirst) == i) begin
                    outLevels[i] <= cmdOp == pfou_pkg::OP_ON_PULSE;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-program format setting
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int p = 0; p < NUM_PROGS; p++) begin
                fmt[p] <= pfou_pkg::FMT_RESET;
            end
        end else if (accept && cmdOp == pfou_pkg::OP_IO_FORMAT) begin
            fmt[cmdProg] <= cmdFirst[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // binary read: pack first..last, stop at the range end or 32 points
    always_comb begin
        int k;
        k       = 0;
        readRaw = '0;
        for (int j = 0; j < RB; j++) begin
            k = int'(cmdFirst) + j;
            if (k <= int'(cmdLast) && k < NUM_PTS) begin
                readRaw[j] = allLevels[k];
            end
        end
    end

    // the raw pattern is kept as is, so a full 32-bit read is signed
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc      <= '0;
            accValid <= 1'b0;
        end else begin
            accValid <= accept && cmdOp == pfou_pkg::OP_READ_BIN;
            if (accept && cmdOp == pfou_pkg::OP_READ_BIN) begin
                acc <= signed'(fmtSwap(readRaw, fmt[cmdProg]));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // level waits: lowest program finishes first, others keep a cycle
    always_comb begin
        doneHit = 1'b0;
        doneP   = '0;
        doneTo  = 1'b0;
        for (int p = NUM_PROGS - 1; p >= 0; p--) begin
            if (wActive[p] && (allLevels[wIdx[p]] == wLvl[p] || wCancel[p]
                               || (wTimed[p] && wCnt[p] == '0))) begin
                doneHit = 1'b1;
                doneP   = PROG_W'(p);
                // a matched level wins over an expiry seen the same cycle
                doneTo  = allLevels[wIdx[p]] != wLvl[p] && !wCancel[p];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wActive <= '0;
            wLvl    <= '0;
            wTimed  <= '0;
            wCancel <= '0;
            for (int p = 0; p < NUM_PROGS; p++) begin
                wIdx[p] <= '0;
                wCnt[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NUM_PROGS; p++) begin
                if (tick && wActive[p] && wTimed[p] && wCnt[p] != '0) begin
                    wCnt[p] <= wCnt[p] - TIME_W'(1);
                end
                if (doneHit && int'(doneP) == p) begin
                    wActive[p] <= 1'b0;
                end
                // an untimed wait is cancelled as if its timer were unlimited
                if (accept && isCancel && int'(cancelProg) == p && wActive[p]) begin
                    wCancel[p] <= 1'b1;
                end
                if (accept && isWait && int'(cmdProg) == p) begin
                    wActive[p] <= 1'b1;
                    wIdx[p]    <= cmdFirst;
                    wLvl[p]    <= cmdOp == pfou_pkg::OP_WAIT_HIGH;
                    wTimed[p]  <= cmdTimed;
                    wCnt[p]    <= cmdTime;
                    wCancel[p] <= 1'b0;
                end
                if (progEnd && int'(progEndId) == p) begin
                    wActive[p] <= 1'b0;
                end
            end
        end
    end

    // completion strobe back to the sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            waitDone     <= 1'b0;
            waitDoneProg <= '0;
            waitTimedOut <= 1'b0;
        end else begin
            waitDone     <= doneHit;
            waitDoneProg <= doneP;
            waitTimedOut <= doneHit && doneTo;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic              prevTarget;
    logic [PROG_W-1:0] cancelTgt;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prevTarget <= 1'b0;
            cancelTgt  <= '0;
        end else begin
            prevTarget <= allLevels[cmdFirst];
            if (accept && isCancel) begin
                cancelTgt <= cancelProg;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence sOwnedPoint;
        int'(cmdFirst) >= IN_PTS && cmdFirst <= cmdLast;
    endsequence
    sequence sSetIssued;
        accept && cmdOp == pfou_pkg::OP_RANGE_SET ##0 sOwnedPoint;
    endsequence
    sequence sClrIssued;
        accept && cmdOp == pfou_pkg::OP_RANGE_CLR ##0 sOwnedPoint;
    endsequence
    sequence sCancelWait;
        accept && isCancel && wActive[cancelProg] && !progEnd;
    endsequence

    a_range_set_on: assert property (sSetIssued |=>
        allLevels[$past(cmdFirst)] && allLevels[$past(cmdLast)])
        else $error("range set missed an end point");
    a_range_clr_off: assert property (sClrIssued |=>
        !allLevels[$past(cmdFirst)] && !allLevels[$past(cmdLast)])
        else $error("range clear missed an end point");
    a_toggle_invert: assert property (accept && cmdOp == pfou_pkg::OP_RANGE_TGL
        && cmdFirst == cmdLast && int'(cmdFirst) >= IN_PTS
        |=> allLevels[$past(cmdFirst)] != prevTarget)
        else $error("toggle did not invert");
    a_on_pulse_drive: assert property (t.load && cmdOp == pfou_pkg::OP_ON_PULSE
        && int'(cmdFirst) >= IN_PTS |-> !t.restoreLvl ##1 allLevels[$past(cmdFirst)])
        else $error("on pulse not driven on with off restore");
    a_off_pulse_drive: assert property (t.load && cmdOp == pfou_pkg::OP_OFF_PULSE
        && int'(cmdFirst) >= IN_PTS |-> t.restoreLvl ##1 !allLevels[$past(cmdFirst)])
        else $error("off pulse not driven off with on restore");
    a_cancel_spares: assert property (accept && isCancel && !progEnd |-> !t.kill)
        else $error("cancel reached pulse timers");
    a_cancel_ends: assert property (sCancelWait |-> ##[2:6]
        (waitDone && waitDoneProg == cancelTgt && !waitTimedOut))
        else $error("cancelled wait did not finish");
    a_wait_timeout: assert property (doneHit && doneTo |->
        wTimed[doneP] && wCnt[doneP] == '0 ##1 waitTimedOut)
        else $error("timeout without expired timed wait");
    a_read_single: assert property (accept && cmdOp == pfou_pkg::OP_READ_BIN
        && cmdFirst == cmdLast && fmt[cmdProg] == 2'h0
        |=> accValid && acc[0] == prevTarget && acc[31:1] == '0)
        else $error("single point read misplaced");
    a_tick_spacing: assert property (tick |=> !tick [*8])
        else $error("ticks too close");
    a_pulse_stall: assert property (cmdValid && isPulse && !t.canLoad |-> !cmdReady)
        else $error("pulse taken with full timer group");

endmodule

// ### core/pfou_pkg.sv
// shared constants and command codes for the port and flag operation unit
package pfou_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and tick timing
    localparam int CLK_HZ      = 20_000_000;
    localparam int TICK_MS     = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    ////////////////////////////////////////////////////////////////////////////
    // point space, programs and timers
    localparam int NUM_PTS      = 1024;
    localparam int IN_PTS       = 256;
    localparam int NUM_PROGS    = 4;
    localparam int TMR_PER_PROG = 16;
    localparam int READ_BITS    = 32;
    localparam int ACC_VAR      = 99;

    // intervals are in hundredths of a second, one tick each
    localparam int TIME_W   = 14;
    localparam int TIME_MIN = 1;
    localparam int TIME_MAX = 9900;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and format field positions
    localparam logic       LVL_RESET    = 1'b0;
    localparam logic [1:0] FMT_RESET    = 2'h0;
    localparam int         FMT_BYTE_BIT = 0;
    localparam int         FMT_HALF_BIT = 1;

    ////////////////////////////////////////////////////////////////////////////
    // command codes
    typedef enum logic [3:0] {
        OP_RANGE_SET  = 4'h0,
        OP_RANGE_CLR  = 4'h1,
        OP_RANGE_TGL  = 4'h2,
        OP_ON_PULSE   = 4'h3,
        OP_OFF_PULSE  = 4'h4,
        OP_WAIT_HIGH  = 4'h5,
        OP_WAIT_LOW   = 4'h6,
        OP_READ_BIN   = 4'h7,
        OP_IO_FORMAT  = 4'h8,
        OP_TMR_CANCEL = 4'h9
    } pfou_op_t;

endpackage

// ### core/pfou_timer_if.sv
// link between the command core and the pulse timer pool
interface pfou_timer_if #(
    parameter int IDX_W  = 10,
    parameter int PROG_W = 2,
    parameter int TIME_W = 14
) ();
    logic              load;
    logic              canLoad;
    logic [PROG_W-1:0] prog;
    logic [IDX_W-1:0]  idx;
    logic              restoreLvl;
    logic [TIME_W-1:0] ticks;
    logic              kill;
    logic [PROG_W-1:0] killProg;
    logic              tick;
    logic              fire;
    logic [IDX_W-1:0]  fireIdx;
    logic              fireLvl;

    modport ctrl (
        output load, prog, idx, restoreLvl, ticks, kill, killProg, tick,
        input  canLoad, fire, fireIdx, fireLvl
    );
    modport tmr (
        input  load, prog, idx, restoreLvl, ticks, kill, killProg, tick,
        output canLoad, fire, fireIdx, fireLvl
    );
endinterface

// ### core/pfou_pulse_timers.sv
// pool of pulse timers, one group of slots per program
module pfou_pulse_timers #(
    parameter int NUM_PROGS    = pfou_pkg::NUM_PROGS,
    parameter int TMR_PER_PROG = pfou_pkg::TMR_PER_PROG,
    parameter int IDX_W        = 10,
    parameter int PROG_W       = 2,
    parameter int TIME_W       = pfou_pkg::TIME_W
) (
    input wire logic   sys_clk,
    input wire logic   rst_n,
    pfou_timer_if.tmr  t
);
    localparam int SLOTS = NUM_PROGS * TMR_PER_PROG;

    logic [SLOTS-1:0]  busy;
    logic [SLOTS-1:0]  sLvl;
    logic [IDX_W-1:0]  sIdx [SLOTS];
    logic [TIME_W-1:0] sCnt [SLOTS];
    logic              freeHit;
    int                freeSlot;
    logic              fireHit;
    int                fireSlot;

    ////////////////////////////////////////////////////////////////////////////
    // lowest free slot in the issuing program's group
    always_comb begin
        freeHit  = 1'b0;
        freeSlot = 0;
        for (int j = TMR_PER_PROG - 1; j >= 0; j--) begin
            if (!busy[int'(t.prog) * TMR_PER_PROG + j]) begin
                freeHit  = 1'b1;
                freeSlot = int'(t.prog) * TMR_PER_PROG + j;
            end
        end
    end

    // one expiry per cycle; a second one simply waits a cycle at zero
    always_comb begin
        fireHit  = 1'b0;
        fireSlot = 0;
        for (int s = SLOTS - 1; s >= 0; s--) begin
            if (busy[s] && sCnt[s] == '0) begin
                fireHit  = 1'b1;
                fireSlot = s;
            end
        end
    end

    assign t.canLoad = freeHit;
    assign t.fire    = fireHit;
    assign t.fireIdx = sIdx[fireSlot];
    assign t.fireLvl = sLvl[fireSlot];

    ////////////////////////////////////////////////////////////////////////////
    // slot state: tick countdown, expiry, group kill, load
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= '0;
            sLvl <= '0;
            for (int s = 0; s < SLOTS; s++) begin
                sIdx[s] <= '0;
                sCnt[s] <= '0;
            end
        end else begin
            for (int s = 0; s < SLOTS; s++) begin
                if (t.tick && busy[s] && sCnt[s] != '0) begin
                    sCnt[s] <= sCnt[s] - TIME_W'(1);
                end
                if (fireHit && fireSlot == s) begin
                    busy[s] <= 1'b0;
                end
                // program ended: drop pending restores, level stays
                if (t.kill && s / TMR_PER_PROG == int'(t.killProg)) begin
                    busy[s] <= 1'b0;
                end
            end
            if (t.load && freeHit) begin
                busy[freeSlot] <= 1'b1;
                sCnt[freeSlot] <= t.ticks;
                sIdx[freeSlot] <= t.idx;
                sLvl[freeSlot] <= t.restoreLvl;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_group_killed: assert property (@(posedge sys_clk) disable iff (!rst_n)
        t.kill && !t.load |=> busy[int'($past(t.killProg)) * TMR_PER_PROG +: TMR_PER_PROG] == '0)
        else $error("pulse slots survive program end");

endmodule

// ### tb/pfou_seq_model.sv
// behavioural program sequencer that issues commands to the unit
module pfou_seq_model (
    input  wire logic          sys_clk,
    input  wire logic          cmdReady,
    output logic               cmdValid,
    output pfou_pkg::pfou_op_t cmdOp,
    output logic [1:0]         cmdProg,
    output logic [9:0]         cmdFirst,
    output logic [9:0]         cmdLast,
    output logic [13:0]        cmdTime,
    output logic               cmdTimed,
    output logic               progEnd,
    output logic [1:0]         progEndId
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cmdValid, cmdProg, cmdFirst, cmdLast, cmdTime, cmdTimed, progEnd, progEndId} = '0;
        cmdOp = pfou_pkg::OP_RANGE_SET;
    end
    // callers keep times in 1..9900, reads within 32 points, waits on shared points only,
    // and never more than sixteen pulses per program in flight
    task automatic issue(input pfou_pkg::pfou_op_t op, input logic [1:0] p, input logic [9:0] f,
                         input logic [9:0] l, input logic [13:0] t, input logic tm);
        int n;
        @(posedge sys_clk);
        // the enum is assigned on its own so its type is kept intact
        cmdOp <= op;
        {cmdValid, cmdProg, cmdFirst, cmdLast, cmdTime, cmdTimed} <= {1'b1, p, f, l, t, tm};
        n = 0;
        // request stands until an edge sees ready high
        do begin
            @(posedge sys_clk);
            n++;
        end while (cmdReady !== 1'b1 && n < 100);
        // a command never taken is a mismatch and ends the run
        if (n == 100) begin
            tb_top.chk(cmdReady, 1'b1);
            tb_top.conclude();
        end
        cmdValid <= 1'b0;
    endtask
    // one-cycle termination notice for a program
    task automatic end_prog(input logic [1:0] p);
        @(posedge sys_clk);
        {progEnd, progEndId} <= {1'b1, p};
        @(posedge sys_clk);
        progEnd <= 1'b0;
    endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the port and flag unit
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic               sys_clk, rst_n, cmdReady, cmdValid, cmdTimed, progEnd, accValid, waitDone, waitTimedOut;
    pfou_pkg::pfou_op_t cmdOp;
    logic [1:0]         cmdProg, progEndId, waitDoneProg;
    logic [9:0]         cmdFirst, cmdLast;
    logic [13:0]        cmdTime;
    logic [255:0]       inLevels;
    logic [1023:256]    outLevels;
    logic signed [31:0] acc;
    int                 err_total, comparisons;
    ////////////////////////////////////////////////////////////////////////////////
    // short tick keeps pulse and wait runs brief
    pfou_core #(.TICK_CYCLES(16)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdProg(cmdProg), .cmdFirst(cmdFirst), .cmdLast(cmdLast),
        .cmdTime(cmdTime), .cmdTimed(cmdTimed), .progEnd(progEnd), .progEndId(progEndId),
        .inLevels(inLevels), .outLevels(outLevels), .accValid(accValid), .acc(acc), .waitDone(waitDone),
        .waitDoneProg(waitDoneProg), .waitTimedOut(waitTimedOut));
    pfou_seq_model seq (.sys_clk(sys_clk), .cmdReady(cmdReady), .cmdValid(cmdValid), .cmdOp(cmdOp),
        .cmdProg(cmdProg), .cmdFirst(cmdFirst), .cmdLast(cmdLast), .cmdTime(cmdTime),
        .cmdTimed(cmdTimed), .progEnd(progEnd), .progEndId(progEndId));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // settle past n edges, n of 0 just lets the current edge land
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_pt(input int idx, input logic lvl);
        int n;
        for (n = 0; n < 80 && outLevels[idx] !== lvl; n++) step(1);
        if (n == 80) begin
            chk(outLevels[idx], lvl);
            conclude();
        end
    endtask
    // waitDone is a one-cycle strobe, so poll every cycle
    task automatic wait_done();
        int n;
        for (n = 0; n < 80 && waitDone !== 1'b1; n++) step(1);
        if (n == 80) begin
            chk(waitDone, 1'b1);
            conclude();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_range();
        seq.issue(pfou_pkg::OP_RANGE_SET, 0, 300, 307, 0, 0);
        step(0);
        chk(outLevels[307:300], 8'hff);
        seq.issue(pfou_pkg::OP_RANGE_CLR, 0, 302, 305, 0, 0);
        step(0);
        chk(outLevels[307:300], 8'hc3);
        seq.issue(pfou_pkg::OP_RANGE_TGL, 0, 300, 303, 0, 0);
        step(0);
        chk(outLevels[307:300], 8'hcc);
        $display("test range done");
    endtask
    task automatic t_pulse();
        seq.issue(pfou_pkg::OP_ON_PULSE, 0, 302, 0, 2, 0);
        seq.issue(pfou_pkg::OP_TMR_CANCEL, 1, 0, 0, 0, 0);
        step(8);
        chk(outLevels[302], 1'b1);
        wait_pt(302, 1'b0);
        seq.issue(pfou_pkg::OP_OFF_PULSE, 0, 300, 0, 2, 0);
        step(10);
        chk(outLevels[300], 1'b0);
        wait_pt(300, 1'b1);
        // two ticks keep the restores well after the program end lands
        seq.issue(pfou_pkg::OP_ON_PULSE, 3, 310, 0, 2, 0);
        seq.issue(pfou_pkg::OP_OFF_PULSE, 3, 306, 0, 2, 0);
        seq.end_prog(3);
        step(60);
        chk({outLevels[310], outLevels[306]}, 2'h2);
        // fill program 2's timer group; ready must then drop with the last pulse op left on the bus
        for (int i = 0; i < 16; i++) seq.issue(pfou_pkg::OP_ON_PULSE, 2, 10'(320 + i), 0, 10, 0);
        step(0);
        chk(cmdReady, 1'b0);
        chk(outLevels[335:320], 16'hffff);
        seq.end_prog(2);
        step(0);
        chk(cmdReady, 1'b1);
        $display("test pulse done");
    endtask
    task automatic t_read();
        @(posedge sys_clk);
        inLevels[39:8] <= 32'h8000_1234;
        seq.issue(pfou_pkg::OP_READ_BIN, 0, 8, 39, 0, 0);
        step(0);
        chk({accValid, acc[31]}, 2'h3);
        chk(acc, 32'h8000_1234);
        seq.issue(pfou_pkg::OP_READ_BIN, 1, 8, 15, 0, 0);
        step(0);
        chk(acc, 32'h0000_0034);
        seq.issue(pfou_pkg::OP_IO_FORMAT, 0, 1, 0, 0, 0);
        seq.issue(pfou_pkg::OP_READ_BIN, 0, 8, 39, 0, 0);
        step(0);
        chk(acc, 32'h0080_3412);
        seq.issue(pfou_pkg::OP_IO_FORMAT, 0, 2, 0, 0, 0);
        seq.issue(pfou_pkg::OP_READ_BIN, 0, 8, 39, 0, 0);
        step(0);
        chk(acc, 32'h1234_8000);
        seq.issue(pfou_pkg::OP_IO_FORMAT, 0, 3, 0, 0, 0);
        seq.issue(pfou_pkg::OP_READ_BIN, 0, 8, 39, 0, 0);
        step(0);
        chk(acc, 32'h3412_0080);
        $display("test read done");
    endtask
    task automatic t_wait();
        seq.issue(pfou_pkg::OP_WAIT_HIGH, 1, 8, 0, 0, 0);
        @(posedge sys_clk);
        inLevels[8] <= 1'b1;
        wait_done();
        chk({waitDoneProg, waitTimedOut}, 3'h2);
        seq.issue(pfou_pkg::OP_WAIT_LOW, 1, 10, 0, 1, 1);
        wait_done();
        chk({waitDoneProg, waitTimedOut}, 3'h3);
        seq.issue(pfou_pkg::OP_WAIT_HIGH, 2, 11, 0, 0, 0);
        seq.issue(pfou_pkg::OP_TMR_CANCEL, 0, 2, 0, 0, 0);
        wait_done();
        chk({waitDoneProg, waitTimedOut}, 3'h4);
        $display("test wait done");
    endtask
    initial begin
        err_total = 0;
        comparisons = 0;
        rst_n = 1'b0;
        inLevels = '0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_range();
        t_pulse();
        t_read();
        t_wait();
        conclude();
    end
endmodule
